// ===== rtl/dcw_decoder.sv
`timescale 1ns/100ps
`include "dcw_params.svh"
// What this block does
// - bit 0 low: ramp down with normal ramp time, switch off at standstill
// - bit 0 rising: become ready; switch motor on if bit 3 high
// - bit 1 low: pulses off at once, coast; switch-on only when high
// - bit 2 low: brake with fast-stop ramp; switch-on only when high
// - bit 3 low: cancel pulses now; high allows pulses and switch-on
// - bit 4 low: force ramp generator output to zero
// - bit 5 low: freeze ramp generator output; high tracks setpoint
// - bit 6 high: accelerate with ramp-up; low: ramp down normally
// - bit 7 rising: acknowledge faults; lockout if a fault is pending and switch-on still active
// - bit 10 low: ignore received process data; high: accept it
// - bit 11 high: invert speed setpoint sign
// - bit 13 high outside telegram 20: increase potentiometer setpoint
// - bit 14 high outside telegram 20: decrease potentiometer setpoint
// - bit 15 selects command data set; reserved under telegram 20
// - switching to telegram 20 keeps previous bit 13 and 14 actions
module dcw_decoder (
    input  wire logic               sys_clk,
    input  wire logic               resetn,
    input  wire logic [15:0]        driveCommandWord,
    input  wire logic               telegramValid,
    input  wire logic [9:0]         telegramNumber,
    input  wire logic               atStandstill,
    input  wire logic               faultPending,
    output dcw_pkg::dcw_state_t     driveState,
    output dcw_pkg::dcw_action_t    actions,
    output logic                    motorOn,
    output logic                    faultAck,
    output logic [15:0]             sampledWord
);

    // ==========================================================
    // command word sampling
    logic [15:0] word_reg, word_next;
    logic [15:0] prev_reg, prev_next;
    logic        ackPulse_reg, ackPulse_next;
    logic        keepPot_reg, keepPot_next;
    logic        potUpHeld_reg, potUpHeld_next;
    logic        potDnHeld_reg, potDnHeld_next;
    logic [9:0]  tgPrev_reg, tgPrev_next;
    logic        sample;
    logic        onEdge;
    logic        ackEdge;
    logic        isTg20;

    assign isTg20 = (telegramNumber == `DCW_TELEGRAM_20);
    // only accepted when bus control asked for in the incoming word
    assign sample = telegramValid && driveCommandWord[`DCW_BIT_BUS_CTRL];
    assign onEdge = sample && driveCommandWord[`DCW_BIT_RAMP_STOP]
                    && !word_reg[`DCW_BIT_RAMP_STOP];
    assign ackEdge = sample && driveCommandWord[`DCW_BIT_FAULT_ACK]
                     && !word_reg[`DCW_BIT_FAULT_ACK];

    always_comb begin
        word_next      = word_reg;
        prev_next      = prev_reg;
        ackPulse_next  = ackEdge;
        keepPot_next   = keepPot_reg;
        potUpHeld_next = potUpHeld_reg;
        potDnHeld_next = potDnHeld_reg;
        tgPrev_next    = telegramNumber;
        if (sample) begin
            word_next = driveCommandWord;
            prev_next = word_reg;
        end
        if (isTg20 && (tgPrev_reg != `DCW_TELEGRAM_20)) begin
            keepPot_next   = 1'b1;
            potUpHeld_next = word_reg[`DCW_BIT_POT_UP];
            potDnHeld_next = word_reg[`DCW_BIT_POT_DOWN];
        end else if (!isTg20) begin
            keepPot_next = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            word_reg      <= `DCW_WORD_RESET;
            prev_reg      <= `DCW_WORD_RESET;
            ackPulse_reg  <= 1'b0;
            keepPot_reg   <= 1'b0;
            potUpHeld_reg <= 1'b0;
            potDnHeld_reg <= 1'b0;
            tgPrev_reg    <= `DCW_TELEGRAM_RESET;
        end else begin
            word_reg      <= word_next;
            prev_reg      <= prev_next;
            ackPulse_reg  <= ackPulse_next;
            keepPot_reg   <= keepPot_next;
            potUpHeld_reg <= potUpHeld_next;
            potDnHeld_reg <= potDnHeld_next;
            tgPrev_reg    <= tgPrev_next;
        end
    end

    // ==========================================================
    // switch-on state machine
    dcw_pkg::dcw_state_t state_reg, state_next;
    logic coastOk;
    logic fastOk;
    logic enableOp;
    logic onCmd;

    assign coastOk  = word_reg[`DCW_BIT_COAST_STOP];
    assign fastOk   = word_reg[`DCW_BIT_FAST_STOP];
    assign enableOp = word_reg[`DCW_BIT_ENABLE_OP];
    assign onCmd    = word_reg[`DCW_BIT_RAMP_STOP];

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            dcw_pkg::ST_LOCKOUT: begin
                if (!onCmd && coastOk && fastOk)
                    state_next = dcw_pkg::ST_READY_TO_START;
            end
            dcw_pkg::ST_READY_TO_START: begin
                if (onEdge && coastOk && fastOk && driveCommandWord[`DCW_BIT_COAST_STOP]
                    && driveCommandWord[`DCW_BIT_FAST_STOP]) begin
                    if (driveCommandWord[`DCW_BIT_ENABLE_OP])
                        state_next = dcw_pkg::ST_RUNNING;
                    else
                        state_next = dcw_pkg::ST_READY;
                end
            end
            dcw_pkg::ST_READY: begin
                if (enableOp)
                    state_next = dcw_pkg::ST_RUNNING;
                if (!onCmd)
                    state_next = dcw_pkg::ST_READY_TO_START;
            end
            dcw_pkg::ST_RUNNING: begin
                if (!enableOp)
                    state_next = dcw_pkg::ST_READY;
                if (!onCmd)
                    state_next = dcw_pkg::ST_RAMP_STOP;
                if (!fastOk)
                    state_next = dcw_pkg::ST_FAST_STOP;
            end
            dcw_pkg::ST_RAMP_STOP: begin
                if (!enableOp || atStandstill)
                    state_next = dcw_pkg::ST_READY_TO_START;
                else if (!fastOk)
                    state_next = dcw_pkg::ST_FAST_STOP;
            end
            dcw_pkg::ST_FAST_STOP: begin
                if (!enableOp || atStandstill)
                    state_next = dcw_pkg::ST_LOCKOUT;
            end
        endcase
        if (!coastOk)
            state_next = dcw_pkg::ST_LOCKOUT;
        if (ackEdge && faultPending && driveCommandWord[`DCW_BIT_RAMP_STOP])
            state_next = dcw_pkg::ST_LOCKOUT;
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn)
            state_reg <= dcw_pkg::ST_LOCKOUT;
        else
            state_reg <= state_next;
    end

    // ==========================================================
    // action outputs
    dcw_pkg::dcw_action_t act_reg, act_next;
    logic running;

    assign running = (state_reg == dcw_pkg::ST_RUNNING);

    always_comb begin
        act_next.pulseEnable  = enableOp && coastOk && (running
                                || state_reg == dcw_pkg::ST_RAMP_STOP
                                || state_reg == dcw_pkg::ST_FAST_STOP);
        act_next.rampDown     = (state_reg == dcw_pkg::ST_RAMP_STOP)
                                || (running && !word_reg[`DCW_BIT_SETP_ENABLE]);
        act_next.fastRampDown = (state_reg == dcw_pkg::ST_FAST_STOP);
        act_next.rampUp       = running && word_reg[`DCW_BIT_SETP_ENABLE];
        act_next.rampZero     = !word_reg[`DCW_BIT_RAMP_ENABLE];
        act_next.rampFreeze   = !word_reg[`DCW_BIT_RAMP_RUN];
        act_next.invertSetpoint = word_reg[`DCW_BIT_INVERT];
        act_next.potUp        = keepPot_reg ? potUpHeld_reg : word_reg[`DCW_BIT_POT_UP];
        act_next.potDown      = keepPot_reg ? potDnHeld_reg : word_reg[`DCW_BIT_POT_DOWN];
        act_next.datasetSelect = isTg20 ? 1'b0 : word_reg[`DCW_BIT_CDS];
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn)
            act_reg <= '0;
        else
            act_reg <= act_next;
    end

    assign actions     = act_reg;
    assign driveState  = state_reg;
    assign motorOn     = act_reg.pulseEnable;
    assign faultAck    = ackPulse_reg;
    assign sampledWord = word_reg;

endmodule

// ===== rtl/dcw_params.svh
`ifndef DCW_PARAMS_SVH
`define DCW_PARAMS_SVH

// command word bit positions
`define DCW_BIT_RAMP_STOP   0
`define DCW_BIT_COAST_STOP  1
`define DCW_BIT_FAST_STOP   2
`define DCW_BIT_ENABLE_OP   3
`define DCW_BIT_RAMP_ENABLE 4
`define DCW_BIT_RAMP_RUN    5
`define DCW_BIT_SETP_ENABLE 6
`define DCW_BIT_FAULT_ACK   7
`define DCW_BIT_BUS_CTRL    10
`define DCW_BIT_INVERT      11
`define DCW_BIT_POT_UP      13
`define DCW_BIT_POT_DOWN    14
`define DCW_BIT_CDS         15

`define DCW_WORD_RESET      16'h0000
`define DCW_TELEGRAM_20     10'h014
`define DCW_TELEGRAM_RESET  10'h001

`endif

// ===== rtl/dcw_pkg.sv
package dcw_pkg;

    typedef enum logic [2:0] {
        ST_LOCKOUT,
        ST_READY_TO_START,
        ST_READY,
        ST_RUNNING,
        ST_RAMP_STOP,
        ST_FAST_STOP
    } dcw_state_t;

    typedef struct packed {
        logic rampDown;
        logic fastRampDown;
        logic rampUp;
        logic pulseEnable;
        logic rampZero;
        logic rampFreeze;
        logic invertSetpoint;
        logic potUp;
        logic potDown;
        logic datasetSelect;
    } dcw_action_t;

endpackage

// ===== verif/dcw_sva.sv
`timescale 1ns/100ps
`include "dcw_params.svh"
module dcw_sva (
    input wire logic           sys_clk,
    input wire logic           resetn,
    input wire logic [15:0]    driveCommandWord,
    input wire logic           telegramValid,
    input wire logic [9:0]     telegramNumber,
    input wire logic           atStandstill,
    input wire logic           faultPending,
    input dcw_pkg::dcw_state_t  driveState,
    input dcw_pkg::dcw_action_t actions,
    input wire logic           motorOn,
    input wire logic           faultAck,
    input wire logic [15:0]    sampledWord
);
    logic take;
    logic ackCause;
    logic cdsExp;
    assign take = telegramValid && driveCommandWord[10];
    assign ackCause = take && driveCommandWord[7] && !sampledWord[7];
    assign cdsExp = sampledWord[15] && telegramNumber != `DCW_TELEGRAM_20;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    property p_take; take |=> sampledWord == $past(driveCommandWord); endproperty
    a_take: assert property (p_take) else $error("word not sampled");
    property p_hold; !take |=> $stable(sampledWord); endproperty
    a_hold: assert property (p_hold) else $error("ignored word taken");
    property p_ack; faultAck == $past(ackCause); endproperty
    a_ack: assert property (p_ack) else $error("ack pulse wrong");
    property p_coast; take && !driveCommandWord[1] |-> ##2 driveState == dcw_pkg::ST_LOCKOUT; endproperty
    a_coast: assert property (p_coast) else $error("coast stop missed");
    property p_pulse; !sampledWord[3] || !sampledWord[1] |=> !motorOn; endproperty
    a_pulse: assert property (p_pulse) else $error("pulses not cancelled");
    property p_zero; 1'b1 |=> actions.rampZero != $past(sampledWord[4]); endproperty
    a_zero: assert property (p_zero) else $error("ramp zero wrong");
    property p_freeze; 1'b1 |=> actions.rampFreeze != $past(sampledWord[5]); endproperty
    a_freeze: assert property (p_freeze) else $error("ramp freeze wrong");
    property p_inv; 1'b1 |=> actions.invertSetpoint == $past(sampledWord[11]); endproperty
    a_inv: assert property (p_inv) else $error("invert wrong");
    property p_cds; $stable(telegramNumber) |=> actions.datasetSelect == $past(cdsExp); endproperty
    a_cds: assert property (p_cds) else $error("dataset select wrong");
    property p_pot; (telegramNumber == `DCW_TELEGRAM_20) [*3] |=> $stable(actions.potUp) && $stable(actions.potDown);
    endproperty
    a_pot: assert property (p_pot) else $error("pot bits not held");
    property p_up; telegramNumber != `DCW_TELEGRAM_20 && $stable(telegramNumber)
        |=> actions.potUp == $past(sampledWord[13]); endproperty
    a_up: assert property (p_up) else $error("pot up wrong");
    c_ack: cover property (faultAck);
    c_run: cover property (driveState == dcw_pkg::ST_RUNNING);
    c_fast: cover property (driveState == dcw_pkg::ST_FAST_STOP);
endmodule
bind dcw_decoder dcw_sva chk_u (
    .sys_clk          (sys_clk),
    .resetn           (resetn),
    .driveCommandWord (driveCommandWord),
    .telegramValid    (telegramValid),
    .telegramNumber   (telegramNumber),
    .atStandstill     (atStandstill),
    .faultPending     (faultPending),
    .driveState       (driveState),
    .actions          (actions),
    .motorOn          (motorOn),
    .faultAck         (faultAck),
    .sampledWord      (sampledWord)
);

// ===== verif/dcw_ctrl_model.sv
`timescale 1ns/100ps
module dcw_ctrl_model (
    input  wire logic        sys_clk,
    output logic [15:0]      word,
    output logic             valid
);
    initial begin
        word = 16'h0000;
        valid = 1'b0;
    end
    // one telegram standing for one rising edge
    task automatic put(input logic [15:0] w);
        word = w & 16'hECFF;
        valid = 1'b1;
        @(negedge sys_clk);
    endtask
    // released word shows its inverse for one edge
    task automatic idle;
        valid = 1'b0;
        word = ~word;
        @(negedge sys_clk);
    endtask
    task automatic send(input logic [15:0] w);
        put(w);
        idle();
    endtask
endmodule

// ===== verif/drive_control_word_decoder_tb.sv
`timescale 1ns/100ps
`include "dcw_params.svh"
module drive_control_word_decoder_tb;
    logic                 sys_clk;
    logic                 resetn;
    logic                 atStandstill;
    logic                 faultPending;
    logic [9:0]           telegramNumber;
    logic [15:0]          word;
    logic [15:0]          sampledWord;
    logic                 valid;
    logic                 motorOn;
    logic                 faultAck;
    dcw_pkg::dcw_state_t  driveState;
    dcw_pkg::dcw_action_t actions;
    int                   n_errors = 0;
    int                   comparisons = 0;
    int                   cyc = 0;
    always #25 sys_clk = ~sys_clk;
    dcw_ctrl_model m_u (.sys_clk, .word, .valid);
    dcw_decoder dut_u (.sys_clk, .resetn, .driveCommandWord(word), .telegramValid(valid), .telegramNumber,
        .atStandstill, .faultPending, .driveState, .actions, .motorOn, .faultAck, .sampledWord);
    task automatic finish_test;
        if (n_errors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic ck(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic bk(input logic g, input logic e);
        ck({15'h0000, g}, {15'h0000, e});
    endtask
    task automatic st(input dcw_pkg::dcw_state_t s);
        ck({13'h0000, driveState}, {13'h0000, s});
    endtask
    task automatic nx(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic up;
        m_u.send(16'h0400);
        m_u.send(16'h0406);
        st(dcw_pkg::ST_READY_TO_START);
        m_u.send(16'h047F);
        st(dcw_pkg::ST_RUNNING);
        nx(1);
        bk(motorOn, 1'b1);
        bk(actions.rampUp, 1'b1);
    endtask
    task automatic t_coast;
        up();
        m_u.send(16'h047D);
        st(dcw_pkg::ST_LOCKOUT);
        nx(1);
        bk(motorOn, 1'b0);
    endtask
    task automatic t_inhibit;
        up();
        m_u.send(16'h0477);
        st(dcw_pkg::ST_READY);
        nx(1);
        bk(motorOn, 1'b0);
    endtask
    task automatic t_fast;
        up();
        m_u.send(16'h047B);
        st(dcw_pkg::ST_FAST_STOP);
        nx(1);
        bk(actions.fastRampDown, 1'b1);
        atStandstill = 1'b1;
        nx(1);
        st(dcw_pkg::ST_LOCKOUT);
        atStandstill = 1'b0;
    endtask
    task automatic t_ramp;
        up();
        m_u.send(16'h047E);
        st(dcw_pkg::ST_RAMP_STOP);
        nx(1);
        bk(actions.rampDown, 1'b1);
        atStandstill = 1'b1;
        nx(1);
        st(dcw_pkg::ST_READY_TO_START);
        atStandstill = 1'b0;
    endtask
    task automatic t_ack;
        up();
        faultPending = 1'b1;
        m_u.put(16'h04FF);
        bk(faultAck, 1'b1);
        st(dcw_pkg::ST_LOCKOUT);
        m_u.idle();
        bk(faultAck, 1'b0);
        faultPending = 1'b0;
    endtask
    task automatic t_word;
        m_u.send(16'h0807);
        ck(sampledWord, 16'h04FF);
        m_u.send(16'h0C07);
        nx(1);
        bk(actions.rampZero, 1'b1);
        bk(actions.rampFreeze, 1'b1);
        bk(actions.invertSetpoint, 1'b1);
    endtask
    task automatic t_tel;
        m_u.send(16'hA47F);
        nx(1);
        bk(actions.potUp, 1'b1);
        bk(actions.datasetSelect, 1'b1);
        telegramNumber = `DCW_TELEGRAM_20;
        nx(1);
        m_u.send(16'hC47F);
        nx(1);
        bk(actions.potUp, 1'b1);
        bk(actions.datasetSelect, 1'b0);
        telegramNumber = `DCW_TELEGRAM_RESET;
        m_u.send(16'hC47F);
        nx(1);
        bk(actions.potDown, 1'b1);
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 1000) begin
            n_errors++;
            finish_test();
        end
    end
    initial begin
        sys_clk = 1'b0;
        resetn = 1'b0;
        atStandstill = 1'b0;
        faultPending = 1'b0;
        telegramNumber = `DCW_TELEGRAM_RESET;
        nx(2);
        resetn = 1'b1;
        t_coast();
        t_inhibit();
        t_fast();
        t_ramp();
        t_ack();
        t_word();
        t_tel();
        finish_test();
    end
endmodule
